/* File: fbscfg_cfg.svh */
// Purpose: Constants of the fieldbus slave mode configuration block
// Assumes: 100 MHz system clock, APB byte addressing
// Notes:   Offsets are register indices; byte address is four times the index
`ifndef FBSCFG_CFG_SVH
`define FBSCFG_CFG_SVH

// Register indices and bus widths
`define FBSCFG_IDX_CFG_LOW     8'h06
`define FBSCFG_IDX_CFG_HIGH    8'h07
`define FBSCFG_IDX_MODE_CTRL   8'h08
`define FBSCFG_IDX_STATUS      8'h0A
`define FBSCFG_ADDR_W          8
`define FBSCFG_DATA_W          32

// Configuration reset values and high byte write mask
`define FBSCFG_CFG_LOW_RST     8'h00
`define FBSCFG_CFG_HIGH_RST    8'h00
`define FBSCFG_CFG_HIGH_MASK   8'h7F

// Low byte field positions
`define FBSCFG_B_FREEZE        7
`define FBSCFG_B_SYNC          6
`define FBSCFG_B_EARLY_RDY     5
`define FBSCFG_B_IRQ_POL       4
`define FBSCFG_B_CLK_SYNC      3
`define FBSCFG_B_WD_SEL        2
`define FBSCFG_B_STOP_OFF      1
`define FBSCFG_B_START_OFF     0

// High byte field positions, counted within the byte
`define FBSCFG_B_REDUND        6
`define FBSCFG_B_FAIL_SAFE     5
`define FBSCFG_B_SPEC_PRM      4
`define FBSCFG_B_EXT_PRM       3
`define FBSCFG_B_USER_SEL      2
`define FBSCFG_B_GAP_SEL       1
`define FBSCFG_B_SLAVE_EN      0

// Mode control bits, write one to act
`define FBSCFG_B_LEAVE_OFL     0
`define FBSCFG_B_EOI           1
`define FBSCFG_B_GO_OFL        2

// Status bits
`define FBSCFG_B_ST_OFFLINE    0
`define FBSCFG_B_ST_IRQ        1
`define FBSCFG_B_ST_GAP        2
`define FBSCFG_B_ST_GO_OFL     3

// Timing
`define FBSCFG_CLK_PERIOD_NS   10
`define FBSCFG_T_1US_NS        1000
`define FBSCFG_T_1MS_NS        1000000
`define FBSCFG_T_10MS_NS       10000000
`define FBSCFG_TICK_W          24

`endif

/* File: fbscfg_host.sv */
// Purpose: APB host model that drives the configuration block
// Assumes: One request at a time, started by a one-cycle go pulse
// Notes:   Released address and data are inverted so stale values never look valid
`timescale 1ns/1ps
`include "fbscfg_cfg.svh"

module fbscfg_host (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_go,
  input  wire logic                        i_write,
  input  wire logic [7:0]                  i_addr,
  input  wire logic [31:0]                 i_wdata,
  input  wire fbscfg_pkg::fbscfg_apb_rsp_t i_apb,
  output fbscfg_pkg::fbscfg_apb_req_t      o_apb,
  output logic                             o_done,
  output logic [31:0]                      o_rdata,
  output logic                             o_err
);
  import fbscfg_pkg::*;

  // Setup, then access held until pready at an edge
  // Config is loaded before the leave request is issued
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_apb   <= '0;
      o_done  <= 1'b0;
      o_rdata <= '0;
      o_err   <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (!o_apb.psel && i_go)
      begin
        o_apb.psel   <= 1'b1;
        o_apb.pwrite <= i_write;
        o_apb.paddr  <= i_addr;
        o_apb.pwdata <= i_wdata;
      end
      else if (o_apb.psel && !o_apb.penable)
        o_apb.penable <= 1'b1;
      else if (o_apb.psel && i_apb.pready)
      begin
        o_apb   <= {3'b000, ~o_apb.paddr, ~o_apb.pwdata};
        o_done  <= 1'b1;
        o_rdata <= i_apb.prdata;
        o_err   <= i_apb.pslverr;
      end
    end
  end
endmodule

/* File: fbscfg_pkg.sv */
// Purpose: Types of the fieldbus slave mode configuration block
// Assumes: Constants come from fbscfg_cfg.svh
// Notes:   APB request and response travel as packed structs
`include "fbscfg_cfg.svh"

package fbscfg_pkg;

  // APB request from the master
  typedef struct packed {
    logic                        psel;
    logic                        penable;
    logic                        pwrite;
    logic [`FBSCFG_ADDR_W-1:0]   paddr;
    logic [`FBSCFG_DATA_W-1:0]   pwdata;
  } fbscfg_apb_req_t;

  // APB response to the master
  typedef struct packed {
    logic                        pready;
    logic [`FBSCFG_DATA_W-1:0]   prdata;
    logic                        pslverr;
  } fbscfg_apb_rsp_t;

  // Decoded configuration seen by the controller
  typedef struct packed {
    logic freeze_enable;
    logic sync_enable;
    logic early_ready;
    logic irq_active_high;
    logic clock_sync_enable;
    logic watchdog_tick_select;
    logic stop_bit_check_off;
    logic start_bit_check_off;
    logic redundancy_param_cmd_enable;
    logic fail_safe_enable;
    logic special_prm_buf_enable;
    logic ext_prm_sap_enable;
    logic user_tick_select;
    logic irq_gap_time_select;
    logic slave_protocol_enable;
  } fbscfg_mode_t;

  // Register selected by an address
  typedef enum logic [2:0] {
    FBSCFG_SEL_NONE = 3'h0,
    FBSCFG_SEL_LOW  = 3'h1,
    FBSCFG_SEL_HIGH = 3'h2,
    FBSCFG_SEL_CTRL = 3'h3,
    FBSCFG_SEL_STAT = 3'h4
  } fbscfg_sel_t;

  // Controller operating state
  typedef enum logic [1:0] {
    FBSCFG_ST_OFFLINE = 2'b00,
    FBSCFG_ST_ONLINE  = 2'b01
  } fbscfg_state_t;

endpackage

/* File: fbscfg_tick.sv */
// Purpose: Periodic tick generator for the watchdog and user time bases
// Assumes: Period is at least two cycles
// Notes:   Counter restarts whenever the tick is disabled
`timescale 1ns/1ps
`include "fbscfg_cfg.svh"

module fbscfg_tick (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_enable,
  input  wire logic [`FBSCFG_TICK_W-1:0] i_period,
  output logic                           o_tick
);

  logic [`FBSCFG_TICK_W-1:0] count_ff;
  logic                      tick_ff;

  // Count up to the period; the period is compared every cycle, so a new one takes hold at once
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end
    else if (!i_enable)
    begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end
    else if (count_ff >= i_period - `FBSCFG_TICK_W'(1))
    begin
      count_ff <= '0;
      tick_ff  <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + `FBSCFG_TICK_W'(1);
      tick_ff  <= 1'b0;
    end
  end

  assign o_tick = tick_ff;

endmodule

/* File: fbscfg_top.sv */
// Purpose: Configuration register of a fieldbus slave controller over APB
// Assumes: Request, telegram and busy inputs come from logic on i_sys_clk
// Notes:   Zero wait state slave; read data is captured in the setup cycle
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "fbscfg_cfg.svh"

module fbscfg_top #(
  parameter int unsigned P_CYC_1MS  = `FBSCFG_T_1MS_NS / `FBSCFG_CLK_PERIOD_NS,
  parameter int unsigned P_CYC_10MS = `FBSCFG_T_10MS_NS / `FBSCFG_CLK_PERIOD_NS
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_sys_rst,
  input  wire fbscfg_pkg::fbscfg_apb_req_t i_apb,
  output fbscfg_pkg::fbscfg_apb_rsp_t  o_apb,
  input  wire logic                    i_irq_request,
  input  wire logic                    i_request_busy,
  input  wire logic                    i_prm_update,
  input  wire logic                    i_prm_stop_off,
  input  wire logic                    i_prm_start_off,
  input  wire logic                    i_data_exchange_state,
  input  wire logic                    i_zero_len_telegram,
  output fbscfg_pkg::fbscfg_mode_t     o_mode,
  output logic                         o_offline,
  output logic                         o_timers_start,
  output logic                         o_end_of_irq,
  output logic                         o_zero_len_accept,
  output logic                         o_irq_pin,
  output logic                         o_wd_tick,
  output logic                         o_user_tick
);

  import fbscfg_pkg::*;

  // Least time, so the gap rounds up to whole cycles
  localparam int unsigned C_GAP_US_CYC =
    (`FBSCFG_T_1US_NS + `FBSCFG_CLK_PERIOD_NS - 1) / `FBSCFG_CLK_PERIOD_NS;
  localparam int C_GAP_US_TAIL = int'(C_GAP_US_CYC) - 8;  // Gap left after eight quiet cycles

  logic [7:0]               cfg_low_ff;
  logic [7:0]               cfg_high_ff;
  logic [7:0]               nxt_cfg_low;
  logic [7:0]               nxt_cfg_high;
  fbscfg_state_t            state_ff;
  fbscfg_state_t            nxt_state;
  logic                     go_offline_ff;
  logic                     timers_start_ff;
  logic                     eoi_ff;
  logic [`FBSCFG_TICK_W-1:0] gap_cnt_ff;
  logic                     gap_active;
  logic                     irq_act_ff;
  logic [`FBSCFG_DATA_W-1:0] prdata_ff;
  fbscfg_sel_t              sel;
  logic                     wr_en;
  logic                     setup;
  logic                     wr_low;
  logic                     wr_high;
  logic                     wr_ctrl;
  logic                     leave_w;
  logic                     eoi_w;
  logic                     go_ofl_w;
  logic                     offline;
  logic [`FBSCFG_TICK_W-1:0] wd_period;
  logic [`FBSCFG_TICK_W-1:0] user_period;

  // Address decode, shared by the read path and the write path
  function automatic fbscfg_sel_t decode(input logic [`FBSCFG_ADDR_W-1:0] addr);
    logic [`FBSCFG_ADDR_W-1:0] idx;
    idx = {2'h0, addr[`FBSCFG_ADDR_W-1:2]};
    if (addr[1:0] != 2'h0)
      decode = FBSCFG_SEL_NONE;
    else if (idx == `FBSCFG_IDX_CFG_LOW)
      decode = FBSCFG_SEL_LOW;
    else if (idx == `FBSCFG_IDX_CFG_HIGH)
      decode = FBSCFG_SEL_HIGH;
    else if (idx == `FBSCFG_IDX_MODE_CTRL)
      decode = FBSCFG_SEL_CTRL;
    else if (idx == `FBSCFG_IDX_STATUS)
      decode = FBSCFG_SEL_STAT;
    else
      decode = FBSCFG_SEL_NONE;
  endfunction

  // Bus phases; the slave never inserts wait states
  assign sel      = decode(i_apb.paddr);
  assign setup    = i_apb.psel & ~i_apb.penable;
  assign wr_en    = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign offline  = (state_ff == FBSCFG_ST_OFFLINE);
  assign wr_low   = wr_en & (sel == FBSCFG_SEL_LOW) & offline;
  assign wr_high  = wr_en & (sel == FBSCFG_SEL_HIGH) & offline;
  assign wr_ctrl  = wr_en & (sel == FBSCFG_SEL_CTRL);
  assign leave_w  = wr_ctrl & i_apb.pwdata[`FBSCFG_B_LEAVE_OFL];
  assign eoi_w    = wr_ctrl & i_apb.pwdata[`FBSCFG_B_EOI];
  assign go_ofl_w = wr_ctrl & i_apb.pwdata[`FBSCFG_B_GO_OFL];

  // Response; an unmapped address answers with an error
  assign o_apb.pready  = 1'b1;
  assign o_apb.prdata  = prdata_ff;
  assign o_apb.pslverr = i_apb.psel & i_apb.penable & (sel == FBSCFG_SEL_NONE);

  // Next configuration; a telegram beats a host write in the same cycle
  always_comb
  begin
    nxt_cfg_low  = cfg_low_ff;
    nxt_cfg_high = cfg_high_ff;
    if (wr_low)
      nxt_cfg_low = i_apb.pwdata[7:0];
    if (wr_high)
      nxt_cfg_high = i_apb.pwdata[7:0] & `FBSCFG_CFG_HIGH_MASK;
    if (i_prm_update && cfg_high_ff[`FBSCFG_B_SLAVE_EN])
    begin
      nxt_cfg_low[`FBSCFG_B_STOP_OFF]  = i_prm_stop_off;
      nxt_cfg_low[`FBSCFG_B_START_OFF] = i_prm_start_off;
    end
  end

  // Configuration storage, cleared at reset
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cfg_low_ff  <= `FBSCFG_CFG_LOW_RST;
      cfg_high_ff <= `FBSCFG_CFG_HIGH_RST;
    end
    else
    begin
      cfg_low_ff  <= nxt_cfg_low;
      cfg_high_ff <= nxt_cfg_high;
    end
  end

  // Offline and online; going offline waits for the running request
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FBSCFG_ST_OFFLINE:
        if (leave_w)
          nxt_state = FBSCFG_ST_ONLINE;
      FBSCFG_ST_ONLINE:
        if (go_offline_ff && !leave_w && !i_request_busy)
          nxt_state = FBSCFG_ST_OFFLINE;
      default:
        nxt_state = FBSCFG_ST_OFFLINE;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_ff <= FBSCFG_ST_OFFLINE;
    else
      state_ff <= nxt_state;
  end

  // Go-offline request; the leave request clears it and wins a tie
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      go_offline_ff <= 1'b0;
    else if (leave_w)
      go_offline_ff <= 1'b0;
    else if (go_ofl_w && !offline)
      go_offline_ff <= 1'b1;
    else if (!i_request_busy)
      go_offline_ff <= 1'b0;
  end

  // Timer start pulse on leaving offline
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      timers_start_ff <= 1'b0;
    else
      timers_start_ff <= leave_w & offline;
  end

  // END_OF_IRQ is only registered as a one-cycle pulse, so it reads back as zero
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      eoi_ff <= 1'b0;
    else
      eoi_ff <= eoi_w;
  end

  // Interrupt gap timer, loaded on END_OF_IRQ with the selected least time
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      gap_cnt_ff <= '0;
    else if (eoi_w && cfg_high_ff[`FBSCFG_B_GAP_SEL])
      gap_cnt_ff <= `FBSCFG_TICK_W'(P_CYC_1MS);
    else if (eoi_w)
      gap_cnt_ff <= `FBSCFG_TICK_W'(C_GAP_US_CYC);
    else if (gap_cnt_ff != '0)
      gap_cnt_ff <= gap_cnt_ff - `FBSCFG_TICK_W'(1);
  end

  assign gap_active = (gap_cnt_ff != '0);

  // Interrupt level; a request during the gap waits until it ends
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      irq_act_ff <= 1'b0;
    else
      irq_act_ff <= i_irq_request & ~eoi_w & ~gap_active;
  end

  // Pin level follows the polarity bit
  assign o_irq_pin = cfg_low_ff[`FBSCFG_B_IRQ_POL] ? irq_act_ff : ~irq_act_ff;

  // Read data captured in the setup cycle so it stands through access
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      prdata_ff <= '0;
    else if (setup)
    begin
      case (sel)
        FBSCFG_SEL_LOW:  prdata_ff <= {24'h000000, cfg_low_ff};
        FBSCFG_SEL_HIGH: prdata_ff <= {24'h000000, cfg_high_ff};
        FBSCFG_SEL_CTRL: prdata_ff <= {29'h0, go_offline_ff, 2'h0};
        FBSCFG_SEL_STAT: prdata_ff <= {28'h0000000, go_offline_ff, gap_active,
                                       irq_act_ff, offline};
        default:         prdata_ff <= '0;
      endcase
    end
  end

  // Decoded mode bits straight from the configuration flops
  assign o_mode.freeze_enable               = cfg_low_ff[`FBSCFG_B_FREEZE];
  assign o_mode.sync_enable                 = cfg_low_ff[`FBSCFG_B_SYNC];
  assign o_mode.early_ready                 = cfg_low_ff[`FBSCFG_B_EARLY_RDY];
  assign o_mode.irq_active_high             = cfg_low_ff[`FBSCFG_B_IRQ_POL];
  assign o_mode.clock_sync_enable           = cfg_low_ff[`FBSCFG_B_CLK_SYNC];
  assign o_mode.watchdog_tick_select        = cfg_low_ff[`FBSCFG_B_WD_SEL];
  assign o_mode.stop_bit_check_off          = cfg_low_ff[`FBSCFG_B_STOP_OFF];
  assign o_mode.start_bit_check_off         = cfg_low_ff[`FBSCFG_B_START_OFF];
  assign o_mode.redundancy_param_cmd_enable = cfg_high_ff[`FBSCFG_B_REDUND];
  assign o_mode.fail_safe_enable            = cfg_high_ff[`FBSCFG_B_FAIL_SAFE];
  assign o_mode.special_prm_buf_enable      = cfg_high_ff[`FBSCFG_B_SPEC_PRM];
  assign o_mode.ext_prm_sap_enable          = cfg_high_ff[`FBSCFG_B_EXT_PRM];
  assign o_mode.user_tick_select            = cfg_high_ff[`FBSCFG_B_USER_SEL];
  assign o_mode.irq_gap_time_select         = cfg_high_ff[`FBSCFG_B_GAP_SEL];
  assign o_mode.slave_protocol_enable       = cfg_high_ff[`FBSCFG_B_SLAVE_EN];

  // Zero length data telegrams pass only in fail-safe data exchange
  assign o_zero_len_accept = cfg_high_ff[`FBSCFG_B_FAIL_SAFE] & i_data_exchange_state &
                             i_zero_len_telegram & ~offline;

  assign o_offline      = offline;
  assign o_timers_start = timers_start_ff;
  assign o_end_of_irq   = eoi_ff;

  // Time base periods; ticks run only while online
  assign wd_period   = cfg_low_ff[`FBSCFG_B_WD_SEL] ? `FBSCFG_TICK_W'(P_CYC_1MS)
                                                    : `FBSCFG_TICK_W'(P_CYC_10MS);
  assign user_period = cfg_high_ff[`FBSCFG_B_USER_SEL] ? `FBSCFG_TICK_W'(P_CYC_10MS)
                                                       : `FBSCFG_TICK_W'(P_CYC_1MS);

  fbscfg_tick u_wd_tick (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (~offline),
    .i_period  (wd_period),
    .o_tick    (o_wd_tick)
  );

  fbscfg_tick u_user_tick (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_enable  (~offline),
    .i_period  (user_period),
    .o_tick    (o_user_tick)
  );

  // Checks on the design's outputs and internal state
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_leave;
    offline && leave_w;
  endsequence

  sequence s_online_start;
    !offline && o_timers_start && !go_offline_ff;
  endsequence

  sequence s_eoi_us;
    eoi_w && !cfg_high_ff[`FBSCFG_B_GAP_SEL];
  endsequence

  a_cfg_write_lock: assert property (
    (wr_en && !offline && !i_prm_update) |=> $stable(cfg_low_ff) && $stable(cfg_high_ff))
    else $error("configuration changed outside offline");

  a_offline_hold: assert property (
    (offline && !leave_w) |=> offline)
    else $error("left offline without request");

  a_leave_start: assert property (
    s_leave |=> s_online_start)
    else $error("leave request did not start timers");

  a_eoi_quiet: assert property (
    eoi_w |=> (!irq_act_ff && o_end_of_irq) ##1 (!irq_act_ff && !o_end_of_irq)[*7])
    else $error("interrupt active right after end of interrupt");

  a_gap_us_len: assert property (
    s_eoi_us ##1 (!eoi_w)[*8] |-> ##C_GAP_US_TAIL gap_active ##1 !gap_active)
    else $error("short interrupt gap length wrong");

  a_gap_ms_load: assert property (
    (eoi_w && cfg_high_ff[`FBSCFG_B_GAP_SEL]) |=> gap_cnt_ff == `FBSCFG_TICK_W'(P_CYC_1MS))
    else $error("long interrupt gap not loaded");

  a_irq_polarity: assert property (
    (!irq_act_ff && !cfg_low_ff[`FBSCFG_B_IRQ_POL]) |-> o_irq_pin)
    else $error("idle interrupt pin not high for active low");

  a_prm_overwrite: assert property (
    (i_prm_update && cfg_high_ff[`FBSCFG_B_SLAVE_EN]) |=>
      o_mode.start_bit_check_off == $past(i_prm_start_off) &&
      o_mode.stop_bit_check_off == $past(i_prm_stop_off))
    else $error("telegram did not overwrite monitoring bits");

  a_zero_len_gate: assert property (
    o_zero_len_accept |-> o_mode.fail_safe_enable && i_data_exchange_state)
    else $error("zero length telegram accepted outside fail-safe exchange");

endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the configuration block
// Assumes: Shortened time bases of 200 and 2000 cycles
// Notes:   Pulse outputs are counted by a monitor to avoid edge races
`timescale 1ns/1ps
`include "fbscfg_cfg.svh"

module tb_top;
  import fbscfg_pkg::*;
  localparam int unsigned C1MS   = 200;
  localparam int unsigned C10MS  = 2000;
  localparam int unsigned C1US   = `FBSCFG_T_1US_NS / `FBSCFG_CLK_PERIOD_NS;
  localparam logic [7:0]  A_LOW  = `FBSCFG_IDX_CFG_LOW << 2;
  localparam logic [7:0]  A_HIGH = `FBSCFG_IDX_CFG_HIGH << 2;
  localparam logic [7:0]  A_CTRL = `FBSCFG_IDX_MODE_CTRL << 2;
  localparam logic [7:0]  A_STAT = `FBSCFG_IDX_STATUS << 2;
  logic            i_sys_clk, i_sys_rst, h_go, h_wr, h_done, h_err;
  logic [7:0]      h_addr;
  logic [31:0]     h_wdata, h_rdata;
  fbscfg_apb_req_t apb_req;
  fbscfg_apb_rsp_t apb_rsp;
  logic            irq_req, busy, prm_upd, prm_stop, prm_start, dx_state, zero_len;
  fbscfg_mode_t    mode;
  logic            offline, t_start, end_of_irq, zl_acc, irq_pin, wd_tick, user_tick;
  int              err_count, n_tests, ts_cnt, eoi_cnt, n;

  fbscfg_top #(.P_CYC_1MS(C1MS), .P_CYC_10MS(C10MS)) fbscfg_top_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_apb(apb_req), .o_apb(apb_rsp),
    .i_irq_request(irq_req), .i_request_busy(busy), .i_prm_update(prm_upd),
    .i_prm_stop_off(prm_stop), .i_prm_start_off(prm_start),
    .i_data_exchange_state(dx_state), .i_zero_len_telegram(zero_len), .o_mode(mode),
    .o_offline(offline), .o_timers_start(t_start), .o_end_of_irq(end_of_irq),
    .o_zero_len_accept(zl_acc), .o_irq_pin(irq_pin), .o_wd_tick(wd_tick),
    .o_user_tick(user_tick));
  fbscfg_host fbscfg_host_inst (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_go(h_go), .i_write(h_wr),
    .i_addr(h_addr), .i_wdata(h_wdata), .i_apb(apb_rsp), .o_apb(apb_req),
    .o_done(h_done), .o_rdata(h_rdata), .o_err(h_err));

  // Clock and pulse monitor
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
  begin
    ts_cnt  <= ts_cnt + int'(t_start === 1'b1);
    eoi_cnt <= eoi_cnt + int'(end_of_irq === 1'b1);
  end

  task automatic summarize();
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // One APB transfer through the host; waits for its completion under a bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    h_go    <= 1'b1;
    h_wr    <= w;
    h_addr  <= a;
    h_wdata <= d;
    @(posedge i_sys_clk);
    h_go <= 1'b0;
    do
    begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end while (h_done !== 1'b1 && k < 20);
    chk(32'(k < 20), 1, "bus hang");
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge i_sys_clk);
    #1;
  endtask

  // Cycles between two consecutive ticks of one time base
  task automatic tick_gap(input logic usr, output int g);
    int k;
    k = 0;
    g = 0;
    while ((usr ? user_tick : wd_tick) !== 1'b1 && k < 5000)
    begin
      cyc(1);
      k++;
    end
    do
    begin
      cyc(1);
      g++;
    end while ((usr ? user_tick : wd_tick) !== 1'b1 && g < 5000);
  endtask

  task automatic t_reset();
    xfer(0, A_LOW, 0);
    chk(h_rdata, 0, "low reset");
    xfer(0, A_HIGH, 0);
    chk(h_rdata, 0, "high reset");
    xfer(0, A_STAT, 0);
    chk(h_rdata[0], 1, "offline after reset");
    chk(mode, 0, "mode reset");
    xfer(0, 8'h40, 0);
    chk(h_err, 1, "unmapped error");
  endtask

  // Distinct patterns expose swapped or stuck fields; last leaves all set
  task automatic t_cfg();
    logic [7:0] lo [3] = '{8'hA5, 8'h5A, 8'hFF};
    logic [7:0] hi [3] = '{8'h5A, 8'hA5, 8'hFF};
    for (int i = 0; i < 3; i++)
    begin
      xfer(1, A_LOW, {24'h0, lo[i]});
      xfer(1, A_HIGH, {24'h0, hi[i]});
      xfer(0, A_LOW, 0);
      chk(h_rdata, {24'h0, lo[i]}, "low readback");
      xfer(0, A_HIGH, 0);
      chk(h_rdata, {24'h0, hi[i] & 8'h7F}, "high readback");
      chk(mode[14:11], lo[i][7:4], "mode low upper");
      chk(mode[10:7], lo[i][3:0], "mode low lower");
      chk(mode[6:4], hi[i][6:4], "mode high upper");
      chk(mode[3:0], hi[i][3:0], "mode high lower");
    end
  endtask

  task automatic t_telegram();
    @(posedge i_sys_clk);
    prm_upd   <= 1'b1;
    prm_start <= 1'b1;
    @(posedge i_sys_clk);
    prm_upd <= 1'b0;
    cyc(1);
    chk(mode[8:7], 2'b01, "telegram monitor bits");
  endtask

  task automatic t_leave();
    xfer(1, A_CTRL, 1);
    cyc(3);
    chk(offline, 0, "online after leave");
    chk(ts_cnt, 1, "timer start pulse");
    xfer(1, A_LOW, 0);
    xfer(0, A_LOW, 0);
    chk(h_rdata, 32'hFD, "online write ignored");
  endtask

  task automatic t_zero();
    @(posedge i_sys_clk);
    dx_state <= 1'b1;
    zero_len <= 1'b1;
    cyc(2);
    chk(zl_acc, 1, "zero length accepted");
    @(posedge i_sys_clk);
    zero_len <= 1'b0;
  endtask

  task automatic t_irq();
    @(posedge i_sys_clk);
    irq_req <= 1'b1;
    cyc(3);
    chk(irq_pin, 1, "irq active high");
    xfer(1, A_CTRL, 2);
    cyc(2);
    chk(irq_pin, 0, "irq dropped");
    chk(eoi_cnt, 1, "eoi pulse");
    n = 0;
    while (irq_pin !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n >= C1MS - 3 && n <= C1MS + 3), 1, "irq gap length");
    @(posedge i_sys_clk);
    irq_req <= 1'b0;
  endtask

  // Go-offline waits for the running request; offline again, config takes writes
  task automatic t_offline();
    @(posedge i_sys_clk);
    busy <= 1'b1;
    xfer(1, A_CTRL, 4);
    cyc(3);
    chk(offline, 0, "offline while request busy");
    xfer(0, A_STAT, 0);
    chk(h_rdata[3:0], 4'h8, "go offline pending");
    @(posedge i_sys_clk);
    busy <= 1'b0;
    cyc(2);
    chk(offline, 1, "offline after request");
    xfer(1, A_HIGH, 32'h7D);
    xfer(0, A_HIGH, 0);
    chk(h_rdata, 32'h7D, "offline write taken");
    xfer(1, A_CTRL, 1);
    cyc(1);
    chk(ts_cnt, 2, "second timer start");
    xfer(0, A_CTRL, 0);
    chk(h_rdata[2], 0, "go offline cleared");
    @(posedge i_sys_clk);
    irq_req <= 1'b1;
    xfer(1, A_CTRL, 2);
    n = 0;
    while (irq_pin !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n >= C1US - 3 && n <= C1US + 3), 1, "short irq gap length");
    chk(eoi_cnt, 2, "second eoi pulse");
    @(posedge i_sys_clk);
    irq_req <= 1'b0;
  endtask

  task automatic t_ticks();
    tick_gap(1'b0, n);
    chk(n, C1MS, "watchdog base");
    tick_gap(1'b1, n);
    chk(n, C10MS, "user tick base");
  endtask

  initial
  begin
    {h_go, h_wr, irq_req, busy, prm_upd, prm_stop, prm_start, dx_state, zero_len} = '0;
    h_addr    = '0;
    h_wdata   = '0;
    err_count = 0;
    n_tests   = 0;
    i_sys_rst = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_cfg();
    t_telegram();
    t_leave();
    t_zero();
    t_irq();
    t_offline();
    t_ticks();
    summarize();
  end

  // Watchdog well beyond the expected run of about 4300 cycles
  initial
  begin
    #200000;
    chk(0, 1, "timeout");
    summarize();
  end
endmodule
